//--- logic/wdr_pkg.sv
/*
 * Constants, register map and types of the watchdog and reset-cause block.
 * Assumes a 100 MHz core clock and an AXI4-Lite master with 32-bit data.
 */
`default_nettype none

package wdr_pkg;

    // ------------------------------------------------------------
    // Clocks and times
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned CLK_NS      = 10;
    // Nominal low-speed oscillator rate, not measured by the logic
    localparam int unsigned LOW_SPEED_INTERNAL_OSC_HZ     = 32_000;
    localparam int unsigned SRESET_NS   = 1000;
    localparam int unsigned SRESET_CYC  = (SRESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned LVR_QUAL_NS = 1000;
    localparam int unsigned LVR_CYC     = (LVR_QUAL_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RST_OUT_CYC = 4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 8;
    localparam logic [7:0]  OFF_WATCHDOG_CONTROL  = 8'h00;
    localparam logic [7:0]  OFF_RESET_CAUSE_FLAGS = 8'h04;
    localparam logic [7:0]  OFF_STAT  = 8'h08;
    localparam logic [7:0]  OFF_CMD   = 8'h0C;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;

    // ------------------------------------------------------------
    // Fields and values
    // ------------------------------------------------------------
    localparam logic [7:0]  WATCHDOG_CONTROL_POR  = 8'h53;
    localparam logic [4:0]  KEY_A     = 5'h0A;
    localparam logic [4:0]  KEY_B     = 5'h15;
    localparam int unsigned KEY_LSB   = 3;
    localparam logic [7:0]  IAP_KEY   = 8'h55;
    localparam int unsigned WRF_BIT   = 0;
    localparam int unsigned LOW_VOLTAGE_RESET_FLAG_BIT  = 2;
    localparam int unsigned TO_BIT    = 0;
    localparam int unsigned PDF_BIT   = 1;
    localparam int unsigned CNT_W     = 18;
    localparam int unsigned INT_N     = 4;

    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_SDLY  = 2'h1,
        ST_RSTO  = 2'h2
    } wdr_state_t;

    // Last count before overflow for each period select
    function automatic logic [CNT_W-1:0] wdr_limit(input logic [2:0] sel);
        logic [CNT_W-1:0] lim;
        lim = 18'h000FF;
        unique case (sel)
            3'h0: lim = 18'h000FF;
            3'h1: lim = 18'h003FF;
            3'h2: lim = 18'h00FFF;
            3'h3: lim = 18'h03FFF;
            3'h4: lim = 18'h07FFF;
            3'h5: lim = 18'h0FFFF;
            3'h6: lim = 18'h1FFFF;
            3'h7: lim = 18'h3FFFF;
        endcase
        return lim;
    endfunction : wdr_limit

endpackage : wdr_pkg

`default_nettype wire

//--- logic/wdr_top.sv
/*
 * Watchdog timer, reset-source control and reset-cause flags.
 * Assumes the CPU core drives the instruction strobes and the low-power
 * level on I_REF_CLK; the oscillator and the low-voltage detector are
 * asynchronous pins. O_SYS_RST is the whole-device reset request.
 */
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module wdr_top
    import wdr_pkg::*;
(
    // Clock and reset
    input  wire logic              I_REF_CLK,
    input  wire logic              I_ARST_N,
    // AXI4-Lite write address and data
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [ADDR_W-1:0] I_AWADDR,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    // AXI4-Lite write response
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    output logic [1:0]             O_BRESP,
    // AXI4-Lite read
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    input  wire logic [ADDR_W-1:0] I_ARADDR,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    // Asynchronous pins
    input  wire logic              I_LOW_SPEED_INTERNAL_OSC_CLK,
    input  wire logic              I_LOW_VOLT,
    // CPU core
    input  wire logic              I_CLEAR_WATCHDOG_INSTRUCTION,
    input  wire logic              I_HALT,
    input  wire logic              I_LOW_PWR,
    input  wire logic [INT_N-1:0]  I_INT_REQ,
    // Reset and wake outputs
    output logic                   O_SYS_RST,
    output logic                   O_PC_SP_CLR,
    output logic                   O_INT_WAKE
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wdr_state_t        st_q;
    wdr_state_t        st_d;
    logic [15:0]       dly_q;
    logic [15:0]       dly_d;
    logic [7:0]        watchdog_control_q;
    logic              wrf_q;
    logic              low_voltage_reset_flag_q;
    logic              to_q;
    logic              pdf_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              osc_s1_q;
    logic              osc_s2_q;
    logic              osc_s3_q;
    logic              lv_s1_q;
    logic              lv_s2_q;
    logic [15:0]       lv_cnt_q;
    logic [INT_N-1:0]  wmask_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic              wstrb0_q;
    logic              tick;
    logic              key_ok;
    logic              ovf;
    logic              lvr_trip;
    logic              wr_go;
    logic              wr_hit;
    logic              iap_go;
    logic              sdone;
    logic              rst_go;
    logic              halt_go;
    logic              clr_go;

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // Third stage only feeds the edge detect, never the first stage
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= I_LOW_SPEED_INTERNAL_OSC_CLK;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lv_s1_q <= 1'b0;
            lv_s2_q <= 1'b0;
        end else begin
            lv_s1_q <= I_LOW_VOLT;
            lv_s2_q <= lv_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // one count per oscillator rising edge
    assign tick     = osc_s2_q & ~osc_s3_q;
    assign key_ok   = (watchdog_control_q[7:KEY_LSB] == KEY_A) || (watchdog_control_q[7:KEY_LSB] == KEY_B);
    assign ovf      = (st_q == ST_RUN) && key_ok && tick && (cnt_q == wdr_limit(watchdog_control_q[2:0]));
    // trips only once low for longer than the qualify time
    assign lvr_trip = lv_s2_q && (lv_cnt_q == 16'(LVR_CYC));
    assign wr_go    = !O_AWREADY && !O_WREADY && !O_BVALID;
    assign wr_hit   = wr_go && wstrb0_q;
    assign iap_go   = wr_hit && (awaddr_q == OFF_CMD) && (wdata_q[7:0] == IAP_KEY);
    assign sdone    = (st_q == ST_SDLY) && (dly_q == 16'(SRESET_CYC - 1));
    assign halt_go  = I_HALT && (st_q == ST_RUN);
    // the clear instruction, halt and a bad key are the software ways to restart the count
    assign clr_go   = I_CLEAR_WATCHDOG_INSTRUCTION && (st_q == ST_RUN);
    // normal-mode overflow, key reset, low voltage and IN_APPLICATION_PROGRAMMING all reset
    assign rst_go   = (st_q != ST_RSTO) && (lvr_trip || iap_go || sdone || (ovf && !I_LOW_PWR));

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d  = st_q;
        dly_d = dly_q + 16'h0001;
        unique case (st_q)
            ST_RUN: begin
                dly_d = 16'h0000;
                // bad key waits the soft-reset delay
                if (!key_ok && !rst_go) begin
                    st_d = ST_SDLY;
                end
            end
            ST_SDLY: begin
                if (rst_go) begin
                    dly_d = 16'h0000;
                end
            end
            ST_RSTO: begin
                if (dly_q == 16'(RST_OUT_CYC - 1)) begin
                    st_d  = ST_RUN;
                    dly_d = 16'h0000;
                end
            end
            default: begin
                st_d  = ST_RSTO;
                dly_d = 16'h0000;
            end
        endcase
        if (rst_go) begin
            st_d  = ST_RSTO;
            dly_d = 16'h0000;
        end
    end

    // power-on starts in reset so the core clears PC and ports
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q      <= ST_RSTO;
            dly_q     <= 16'h0000;
            O_SYS_RST <= 1'b1;
        end else begin
            st_q      <= st_d;
            dly_q     <= dly_d;
            O_SYS_RST <= (st_d == ST_RSTO);
        end
    end

    // ------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------
    // cleared by bad key, clear instruction and halt
    // held at zero through every reset
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cnt_q <= '0;
        end else if (st_q != ST_RUN || !key_ok || clr_go || halt_go) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= ovf ? '0 : cnt_q + 18'h00001;
        end
    end

    // low-power overflow only clears PC and SP
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PC_SP_CLR <= 1'b0;
        end else begin
            O_PC_SP_CLR <= ovf && I_LOW_PWR;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // power-on clears both; low-voltage reset leaves both
    // halt clears time-out; an overflow in the same cycle wins
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            to_q <= 1'b0;
        end else if (ovf) begin
            to_q <= 1'b1;
        end else if (halt_go) begin
            to_q <= 1'b0;
        end
    end

    // Clear instruction also ends the power-down indication
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pdf_q <= 1'b0;
        end else if (halt_go) begin
            pdf_q <= 1'b1;
        end else if (clr_go) begin
            pdf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Low-voltage qualification
    // ------------------------------------------------------------
    // disabled and forgotten while in sleep or idle
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            lv_cnt_q <= 16'h0000;
        end else if (!lv_s2_q || I_LOW_PWR || st_q == ST_RSTO) begin
            lv_cnt_q <= 16'h0000;
        end else if (lv_cnt_q != 16'(LVR_CYC)) begin
            lv_cnt_q <= lv_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Control and reset-cause registers
    // ------------------------------------------------------------
    // power-on key and period; reloaded by each reset so a bad
    // key cannot keep the device in reset forever
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            watchdog_control_q <= WATCHDOG_CONTROL_POR;
        end else if (rst_go) begin
            watchdog_control_q <= WATCHDOG_CONTROL_POR;
        end else if (wr_hit && awaddr_q == OFF_WATCHDOG_CONTROL) begin
            watchdog_control_q <= wdata_q[7:0];
        end
    end

    // hardware set beats a software clear in the same cycle
    // low-voltage flag behaves the same way
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wrf_q  <= 1'b0;
            low_voltage_reset_flag_q <= 1'b0;
        end else begin
            if (sdone) begin
                wrf_q <= 1'b1;
            end else if (wr_hit && awaddr_q == OFF_RESET_CAUSE_FLAGS) begin
                wrf_q <= wdata_q[WRF_BIT];
            end
            // qualified low supply marks its cause
            if (lvr_trip && st_q != ST_RSTO) begin
                low_voltage_reset_flag_q <= 1'b1;
            end else if (wr_hit && awaddr_q == OFF_RESET_CAUSE_FLAGS) begin
                low_voltage_reset_flag_q <= wdata_q[LOW_VOLTAGE_RESET_FLAG_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Wake masking
    // ------------------------------------------------------------
    // requests pending at halt are masked for this low-power stay
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            wmask_q    <= '0;
            O_INT_WAKE <= 1'b0;
        end else begin
            if (halt_go) begin
                wmask_q <= ~I_INT_REQ;
            end
            O_INT_WAKE <= I_LOW_PWR && !halt_go && |(I_INT_REQ & wmask_q);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
            O_BVALID  <= 1'b0;
            O_BRESP   <= RESP_OK;
            awaddr_q  <= '0;
            wdata_q   <= 32'h00000000;
            wstrb0_q  <= 1'b0;
        end else begin
            if (O_AWREADY && I_AWVALID) begin
                O_AWREADY <= 1'b0;
                awaddr_q  <= I_AWADDR;
            end
            if (O_WREADY && I_WVALID) begin
                O_WREADY <= 1'b0;
                wdata_q  <= I_WDATA;
                wstrb0_q <= I_WSTRB[0];
            end
            if (wr_go) begin
                O_BVALID <= 1'b1;
                O_BRESP  <= (awaddr_q == OFF_WATCHDOG_CONTROL || awaddr_q == OFF_RESET_CAUSE_FLAGS ||
                             awaddr_q == OFF_STAT || awaddr_q == OFF_CMD) ? RESP_OK : RESP_ERR;
            end
            if (O_BVALID && I_BREADY) begin
                O_BVALID  <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY  <= 1'b1;
            end
        end
    end

    // unimplemented flag bits read as zero
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_ARREADY <= 1'b1;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h00000000;
            O_RRESP   <= RESP_OK;
        end else if (O_ARREADY && I_ARVALID) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b1;
            O_RDATA   <= 32'h00000000;
            O_RRESP   <= RESP_OK;
            unique case (I_ARADDR)
                OFF_WATCHDOG_CONTROL:  O_RDATA[7:0] <= watchdog_control_q;
                OFF_RESET_CAUSE_FLAGS: O_RDATA[7:0] <= {5'h00, low_voltage_reset_flag_q, 1'b0, wrf_q};
                OFF_STAT:  O_RDATA[7:0] <= {6'h00, pdf_q, to_q};
                OFF_CMD:   O_RDATA[7:0] <= 8'h00;
                default:   O_RRESP      <= RESP_ERR;
            endcase
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID  <= 1'b0;
            O_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int A_SDLY = SRESET_CYC + 1;

    default clocking a_clk @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);

    a_key_to_delay: assert property (
        (st_q == ST_RUN && !key_ok && !rst_go) |=> st_q == ST_SDLY)
        else $error("bad key did not start soft-reset delay");

    a_delay_to_rst: assert property (
        $rose(st_q == ST_SDLY) && !rst_go |-> ##[1:A_SDLY] O_SYS_RST)
        else $error("soft reset did not follow its delay");

    a_soft_flag_set: assert property (
        sdone |=> wrf_q && O_SYS_RST)
        else $error("soft reset flag not set");

    a_soft_flag_hold: assert property (
        wrf_q && !(wr_hit && awaddr_q == OFF_RESET_CAUSE_FLAGS) |=> wrf_q)
        else $error("soft reset flag lost without a write");

    a_ovf_normal: assert property (
        ovf && !I_LOW_PWR |=> to_q && O_SYS_RST && cnt_q == '0)
        else $error("normal overflow did not reset");

    a_ovf_sleep: assert property (
        ovf && I_LOW_PWR && !lvr_trip && !iap_go |=> to_q && O_PC_SP_CLR && !O_SYS_RST)
        else $error("low-power overflow handled wrongly");

    a_halt_flags: assert property (
        halt_go && !ovf |=> pdf_q && !to_q && cnt_q == '0)
        else $error("halt did not set flags or clear count");

    a_clr_count: assert property (
        clr_go |=> cnt_q == '0)
        else $error("clear instruction left count");

    a_lvr_sleep_off: assert property (
        I_LOW_PWR |=> !lvr_trip)
        else $error("low-voltage reset active in low power");

    a_iap_reset: assert property (
        iap_go |=> O_SYS_RST [*4])
        else $error("programming command did not reset");

endmodule : wdr_top

`default_nettype wire

//--- verif/wdr_top_tb.sv
/*
 * Self-checking bench of wdr_top: register bus, watchdog periods, clear and
 * halt, low-power overflow, wake masking, soft, low-voltage and command resets.
 * Assumes only the design files; the bench drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none

module wdr_top_tb;
    import wdr_pkg::*;

    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic        low_speed_internal_osc = 0, lowv = 0, clr = 0, halt = 0, lpwr = 0;
    logic [3:0]  irq = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, seed = 32'd4060;
    logic [1:0]  br, rr;
    logic        awr, wrdy, bv, arr, rv, sys_rst, pcsp, wake;
    int          n_errors = 0, cmp_count = 0, mdl[3];
    int          per[8] = '{256, 1024, 4096, 16384, 32768, 65536, 131072, 262144};

    always #5 clk = ~clk;

    wdr_top i_dut (.I_REF_CLK(clk), .I_ARST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF),
        .O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
        .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rd), .O_RRESP(rr),
        .I_LOW_SPEED_INTERNAL_OSC_CLK(low_speed_internal_osc), .I_LOW_VOLT(lowv), .I_CLEAR_WATCHDOG_INSTRUCTION(clr), .I_HALT(halt),
        .I_LOW_PWR(lpwr), .I_INT_REQ(irq), .O_SYS_RST(sys_rst), .O_PC_SP_CLR(pcsp),
        .O_INT_WAKE(wake));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    // Write holds each channel until its own ready, bready until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        @(posedge clk);
        awv <= 1;
        wv  <= 1;
        awa <= a;
        wd  <= d;
        bre <= 1;
        for (t = 0; t < 50 && bv !== 1'b1; t++) begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 0;
            if (wrdy === 1'b1) wv <= 0;
        end
        if (t >= 50) n_errors++;
        bre <= 0;
        chk(br, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int t;
        @(posedge clk);
        arv <= 1;
        ara <= a;
        rre <= 1;
        for (t = 0; t < 50 && rv !== 1'b1; t++) begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 0;
        end
        if (t >= 50) n_errors++;
        rre <= 0;
        chk(rr, er);
        if (er == RESP_OK) chk(rd, e);
    endtask : rd_chk

    task automatic chk_reg(input int i);
        rd_chk(8'(i * 4), 32'(mdl[i]), RESP_OK);
    endtask : chk_reg

    task automatic tick(input int k);
        repeat (k) begin
            low_speed_internal_osc <= 1;
            cyc(3);
            low_speed_internal_osc <= 0;
            cyc(3);
        end
    endtask : tick

    // Cycles until the reset (or PC/SP clear) output is seen, -1 if never
    task automatic wt(input bit pc, input int lim, output int c);
        for (c = 1; c <= lim; c++) begin
            @(posedge clk);
            if ((pc ? pcsp : sys_rst) === 1'b1) return;
        end
        c = -1;
    endtask : wt

    task automatic settle();
        int c;
        for (c = 0; c < 50 && sys_rst !== 1'b0; c++) @(posedge clk);
        if (c >= 50) n_errors++;
        cyc(2);
    endtask : settle

    task automatic pulse(input bit h);
        if (h) halt <= 1;
        else clr <= 1;
        @(posedge clk);
        halt <= 0;
        clr  <= 0;
    endtask : pulse

    // One tick short of the period must stay quiet, the next one overflows
    task automatic ovf(input int s, input bit pc);
        int c;
        tick(per[s] - 1);
        cyc(6);
        chk({sys_rst, pcsp}, 0);
        low_speed_internal_osc <= 1;
        wt(pc, 12, c);
        low_speed_internal_osc <= 0;
        chk(c > 0, 1);
        settle();
    endtask : ovf

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [4:0] k;
        int         c, i;
        cyc(20);
        rst_n <= 1;
        settle();
        mdl = '{32'(WATCHDOG_CONTROL_POR), 0, 0};
        for (i = 0; i < 3; i++) chk_reg(i);
        rd_chk(8'h10, 0, RESP_ERR);
        wr(8'h10, xs(), RESP_ERR);
        rd_chk(OFF_CMD, 0, RESP_OK);
        $display("test reset values done");
        for (i = 0; i < 8; i++) begin
            mdl[0] = {(i % 2) ? KEY_B : KEY_A, 3'(i)};
            wr(OFF_WATCHDOG_CONTROL, (xs() & 32'hFFFF_FF00) | 32'(mdl[0]), RESP_OK);
            chk_reg(0);
        end
        $display("test control readback done");
        for (i = 0; i < 2; i++) begin
            wr(OFF_WATCHDOG_CONTROL, {24'h0, KEY_A, 3'(i)}, RESP_OK);
            ovf(i, 0);
            mdl[0] = 32'(WATCHDOG_CONTROL_POR);
            mdl[2] = 1;
            chk_reg(0);
            chk_reg(2);
        end
        $display("test overflow periods done");
        wr(OFF_WATCHDOG_CONTROL, {24'h0, KEY_B, 3'h0}, RESP_OK);
        tick(200);
        // software clears before the period ends
        pulse(0);
        ovf(0, 0);
        $display("test clear instruction done");
        wr(OFF_WATCHDOG_CONTROL, {24'h0, KEY_A, 3'h0}, RESP_OK);
        irq <= 4'h1;
        pulse(1);
        mdl[2] = 2;
        chk_reg(2);
        lpwr <= 1;
        ovf(0, 1);
        chk(sys_rst, 0);
        mdl[2] = 3;
        chk_reg(2);
        chk(wake, 0);
        irq <= 4'h5;
        cyc(3);
        chk(wake, 1);
        lowv <= 1;
        wt(0, 200, c);
        chk(c, -1);
        lowv <= 0;
        cyc(5);
        lpwr <= 0;
        irq  <= 0;
        pulse(0);
        mdl[2] = 1;
        chk_reg(2);
        $display("test low power done");
        k = 5'(xs());
        while (k == KEY_A || k == KEY_B) k = 5'(xs());
        wr(OFF_WATCHDOG_CONTROL, {24'h0, k, 3'(xs())}, RESP_OK);
        wt(0, 200, c);
        chk(c >= SRESET_CYC - 2 && c <= SRESET_CYC + 6, 1);
        settle();
        mdl[0] = 32'(WATCHDOG_CONTROL_POR);
        mdl[1] = 1;
        chk_reg(0);
        chk_reg(1);
        wr(OFF_RESET_CAUSE_FLAGS, 0, RESP_OK);
        mdl[1] = 0;
        chk_reg(1);
        $display("test soft reset done");
        lowv <= 1;
        wt(0, LVR_CYC - 5, c);
        lowv <= 0;
        chk(c, -1);
        wt(0, 20, c);
        chk(c, -1);
        lowv <= 1;
        wt(0, LVR_CYC + 20, c);
        lowv <= 0;
        chk(c > LVR_CYC && c <= LVR_CYC + 8, 1);
        settle();
        mdl[1] = 4;
        for (i = 0; i < 3; i++) chk_reg(i);
        wr(OFF_RESET_CAUSE_FLAGS, 0, RESP_OK);
        mdl[1] = 0;
        chk_reg(1);
        $display("test low voltage done");
        wr(OFF_CMD, 32'h54, RESP_OK);
        wt(0, 10, c);
        chk(c, -1);
        wr(OFF_CMD, (xs() & 32'hFFFF_FF00) | 32'(IAP_KEY), RESP_OK);
        wt(0, 10, c);
        chk(c > 0, 1);
        settle();
        chk_reg(0);
        $display("test command reset done");
        rst_n <= 0;
        cyc(2);
        chk(sys_rst, 1);
        rst_n <= 1;
        settle();
        mdl = '{32'(WATCHDOG_CONTROL_POR), 0, 0};
        for (i = 0; i < 3; i++) chk_reg(i);
        $display("test power-on reset done");
        end_sim();
    end

    // Hang guard, about twice the expected run
    initial begin
        #300_000;
        n_errors++;
        end_sim();
    end

endmodule : wdr_top_tb

`default_nettype wire
